// *** rtl/fcs_sequencer.sv ***
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module fcs_sequencer
    import fcs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = SEC_CYCLES
) (
    // clock and reset
    input  wire logic              SYS_CLK,
    input  wire logic              SRST,
    // register port
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    input  wire logic [DATA_W-1:0] REG_WDATA,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    output logic      [DATA_W-1:0] REG_RDATA,
    // control inputs
    input  wire logic              STEP_TRIGGER_INPUT,
    input  wire logic              HOLD_INPUT,
    input  wire logic              RESUME_INPUT,
    input  wire logic              ABORT_INPUT,
    // contact outputs
    output logic      [PAT_W-1:0]  CONTACT_OUTPUTS
);
    fcs_pulse_if pif ();

    // configuration and step tables
    logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [STEP_W-1:0] nsteps_r, nsteps_nxt;
    logic [REP_W-1:0]  repeat_r, repeat_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [PAT_W-1:0]  pat_mem  [0:MAX_STEP];
    logic [INTV_W-1:0] intv_mem [0:MAX_STEP];
    // sequencer state
    fcs_state_t        state_r, state_nxt;
    logic [STEP_W-1:0] step_r, step_nxt;
    logic [INTV_W-1:0] remain_r, remain_nxt;
    logic              paused_r, paused_nxt;
    logic              armed_r, armed_nxt;
    logic [REP_W-1:0]  cycles_r, cycles_nxt;
    logic [PAT_W-1:0]  out_r, out_nxt;
    logic [TICK_W-1:0] presc_r, presc_nxt;
    // decode and helpers
    logic              pat_hit, intv_hit;
    logic [STEP_W-1:0] tab_idx;
    logic              mode_time, autostart, loop_inf;
    logic              tick, load, advance;
    logic [REP_W-1:0]  cycles_inc;

    // input conditioning, one instance for all four lanes
    fcs_edge_det #(.WIDTH(IN_W)) u_edge (
        .clk (SYS_CLK),
        .rst (SRST),
        .raw ({ABORT_INPUT, RESUME_INPUT, HOLD_INPUT, STEP_TRIGGER_INPUT}),
        .pif (pif.src)
    );

    assign mode_time = ctrl_r[CTRL_TIME_BIT];
    assign autostart = ctrl_r[CTRL_AUTO_BIT];
    assign loop_inf  = ctrl_r[CTRL_LOOP_BIT];

    // table address decode, entry 0 is never mapped
    assign tab_idx  = REG_ADDR[STEP_W+1:2];
    assign pat_hit  = (REG_ADDR[7:6] == PAT_BASE_OFS[7:6]) && (REG_ADDR[1:0] == 2'h0)
                      && (tab_idx != '0);
    assign intv_hit = (REG_ADDR[7:6] == INTV_BASE_OFS[7:6]) && (REG_ADDR[1:0] == 2'h0)
                      && (tab_idx != '0);

    // register writes and read data
    always_comb begin
        ctrl_nxt   = ctrl_r;
        nsteps_nxt = nsteps_r;
        repeat_nxt = repeat_r;
        rdata_nxt  = '0;
        if (REG_WR) begin
            if (REG_ADDR == CTRL_OFS) begin
                ctrl_nxt = REG_WDATA[CTRL_W-1:0];
            end else if (REG_ADDR == NSTEPS_OFS) begin
                nsteps_nxt = REG_WDATA[STEP_W-1:0];
            end else if (REG_ADDR == REPEAT_OFS) begin
                repeat_nxt = REG_WDATA[REP_W-1:0];
            end
        end
        if (REG_RD) begin
            if (REG_ADDR == CTRL_OFS) begin
                rdata_nxt[CTRL_W-1:0] = ctrl_r;
            end else if (REG_ADDR == NSTEPS_OFS) begin
                rdata_nxt[STEP_W-1:0] = nsteps_r;
            end else if (REG_ADDR == REPEAT_OFS) begin
                rdata_nxt[REP_W-1:0] = repeat_r;
            end else if (REG_ADDR == STATUS_OFS) begin
                rdata_nxt[STAT_STEP_LSB +: STEP_W] = step_r;
                rdata_nxt[STAT_RUN_BIT]            = (state_r == ST_RUN);
                rdata_nxt[STAT_HOLD_BIT]           = paused_r;
                rdata_nxt[STAT_OUT_LSB +: PAT_W]   = out_r;
            end else if (REG_ADDR == CYCLES_OFS) begin
                rdata_nxt[REP_W-1:0] = cycles_r;
            end else if (REG_ADDR == REMAIN_OFS) begin
                rdata_nxt[INTV_W-1:0] = remain_r;
            end else if (pat_hit) begin
                rdata_nxt[PAT_W-1:0] = pat_mem[tab_idx];
            end else if (intv_hit) begin
                rdata_nxt[INTV_W-1:0] = intv_mem[tab_idx];
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ctrl_r   <= CTRL_RST;
            nsteps_r <= NSTEPS_RST;
            repeat_r <= REPEAT_RST;
            rdata_r  <= '0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            nsteps_r <= nsteps_nxt;
            repeat_r <= repeat_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // step tables, one pattern and one interval per step
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            for (int i = 0; i <= MAX_STEP; i++) begin
                pat_mem[i]  <= IDLE_PAT;
                intv_mem[i] <= '0;
            end
        end else if (REG_WR && pat_hit) begin
            pat_mem[tab_idx] <= REG_WDATA[PAT_W-1:0];
        end else if (REG_WR && intv_hit) begin
            intv_mem[tab_idx] <= REG_WDATA[INTV_W-1:0];
        end
    end

    // one-second prescaler, restarted on each step load, frozen on hold in time mode
    always_comb begin
        tick      = (presc_r == TICK_W'(TICK_CYCLES - 1));
        presc_nxt = tick ? '0 : presc_r + 1'b1;
        if (load) begin
            presc_nxt = '0;
        end else if (paused_r && mode_time) begin
            presc_nxt = presc_r;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            presc_r <= '0;
        end else begin
            presc_r <= presc_nxt;
        end
    end

    // step sequencing
    always_comb begin
        state_nxt  = state_r;
        step_nxt   = step_r;
        remain_nxt = remain_r;
        paused_nxt = paused_r;
        armed_nxt  = armed_r;
        cycles_nxt = cycles_r;
        load       = 1'b0;
        advance    = 1'b0;
        cycles_inc = REP_W'(cycles_r + 1'b1);
        if (pif.pulse[IN_ABORT]) begin
            // abort at once; armed reruns from step 1 when autostart is set
            state_nxt  = ST_IDLE;
            step_nxt   = '0;
            paused_nxt = 1'b0;
            armed_nxt  = 1'b1;
            cycles_nxt = '0;
        end else if (state_r == ST_IDLE) begin
            paused_nxt = 1'b0;
            if (pif.pulse[IN_START] || (autostart && armed_r)) begin
                state_nxt  = ST_RUN;
                step_nxt   = 4'h1;
                remain_nxt = intv_mem[1];
                armed_nxt  = 1'b1;
                load       = 1'b1;
            end
        end else begin
            // hold wins over resume in the same cycle
            if (pif.pulse[IN_HOLD]) begin
                paused_nxt = 1'b1;
            end else if (pif.pulse[IN_RESUME]) begin
                paused_nxt = 1'b0;
            end
            if (mode_time) begin
                advance = !paused_r && tick && (remain_r <= 19'h00001);
                if (!paused_r && tick && (remain_r > 19'h00001)) begin
                    remain_nxt = remain_r - 1'b1;
                end
            end else begin
                advance = !paused_r && pif.pulse[IN_START];
            end
            if (advance) begin
                load = 1'b1;
                if (step_r < nsteps_r) begin
                    step_nxt   = step_r + 1'b1;
                    remain_nxt = intv_mem[step_r + 1'b1];
                end else if (!loop_inf && (cycles_inc >= repeat_r)) begin
                    // repetitions used up: rest idle until a start pulse, or an abort with autostart set
                    state_nxt  = ST_IDLE;
                    step_nxt   = '0;
                    armed_nxt  = 1'b0;
                    cycles_nxt = '0;
                end else if (autostart) begin
                    step_nxt   = 4'h1;
                    remain_nxt = intv_mem[1];
                    cycles_nxt = cycles_inc;
                end else begin
                    state_nxt  = ST_IDLE;
                    step_nxt   = '0;
                    cycles_nxt = cycles_inc;
                end
            end
        end
        // step 0 always shows the fixed idle pattern
        out_nxt = (step_nxt == '0) ? IDLE_PAT : pat_mem[step_nxt];
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            state_r  <= ST_IDLE;
            step_r   <= '0;
            remain_r <= '0;
            paused_r <= 1'b0;
            armed_r  <= 1'b1;
            cycles_r <= '0;
            out_r    <= IDLE_PAT;
        end else begin
            state_r  <= state_nxt;
            step_r   <= step_nxt;
            remain_r <= remain_nxt;
            paused_r <= paused_nxt;
            armed_r  <= armed_nxt;
            cycles_r <= cycles_nxt;
            out_r    <= out_nxt;
        end
    end

    assign REG_RDATA       = rdata_r;
    assign CONTACT_OUTPUTS = out_r;
endmodule : fcs_sequencer

// *** pkg/fcs_pkg.sv ***
package fcs_pkg;
    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // sequence geometry
    localparam int PAT_W    = 4;
    localparam int IN_W     = 4;
    localparam int STEP_W   = 4;
    localparam int MAX_STEP = 15;
    localparam int INTV_W   = 19;
    localparam int REP_W    = 20;
    // control input lanes
    localparam int IN_START  = 0;
    localparam int IN_HOLD   = 1;
    localparam int IN_RESUME = 2;
    localparam int IN_ABORT  = 3;
    // register offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS      = 8'h00;
    localparam logic [ADDR_W-1:0] NSTEPS_OFS    = 8'h04;
    localparam logic [ADDR_W-1:0] REPEAT_OFS    = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFS    = 8'h0C;
    localparam logic [ADDR_W-1:0] CYCLES_OFS    = 8'h10;
    localparam logic [ADDR_W-1:0] REMAIN_OFS    = 8'h14;
    localparam logic [ADDR_W-1:0] PAT_BASE_OFS  = 8'h40;
    localparam logic [ADDR_W-1:0] INTV_BASE_OFS = 8'h80;
    // control register fields
    localparam int CTRL_TIME_BIT = 0;
    localparam int CTRL_AUTO_BIT = 1;
    localparam int CTRL_LOOP_BIT = 2;
    localparam int CTRL_W        = 3;
    // status register fields
    localparam int STAT_STEP_LSB = 0;
    localparam int STAT_RUN_BIT  = 4;
    localparam int STAT_HOLD_BIT = 5;
    localparam int STAT_OUT_LSB  = 8;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST   = 3'h0;
    localparam logic [STEP_W-1:0] NSTEPS_RST = 4'h1;
    localparam logic [REP_W-1:0]  REPEAT_RST = 20'h00001;
    localparam logic [PAT_W-1:0]  IDLE_PAT   = 4'h0;
    // timing: one-second tick from the system clock
    localparam int CLK_PERIOD_NS = 50;
    localparam int SEC_NS        = 1000000000;
    localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
    localparam int TICK_W        = 25;
    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } fcs_state_t;
endpackage : fcs_pkg

// *** pkg/fcs_pulse_if.sv ***
`timescale 1ns/1ps
interface fcs_pulse_if;
    import fcs_pkg::*;
    logic [IN_W-1:0] pulse;
    modport src (output pulse);
    modport dst (input pulse);
endinterface : fcs_pulse_if

// *** rtl/fcs_edge_det.sv ***
`timescale 1ns/1ps
module fcs_edge_det
    import fcs_pkg::*;
#(
    parameter int WIDTH = IN_W
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // raw control levels
    input  wire logic [WIDTH-1:0] raw,
    // one-cycle action pulses
    fcs_pulse_if.src              pif
);
    logic [WIDTH-1:0] s1_r, s2_r, s3_r;
    logic [WIDTH-1:0] s1_nxt, s2_nxt, s3_nxt;

    // two-stage synchroniser then edge history
    always_comb begin
        s1_nxt = raw;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end

    // one pulse per rising edge, however long the level
    assign pif.pulse = s2_r & ~s3_r;
endmodule : fcs_edge_det

// *** test/fcs_seq_chk_assertions.sv ***
`timescale 1ns/1ps
module fcs_seq_chk
    import fcs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = SEC_CYCLES
) (
    // clock and reset
    input wire logic              SYS_CLK,
    input wire logic              SRST,
    // register port
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic              REG_WR,
    input wire logic              REG_RD,
    input wire logic [DATA_W-1:0] REG_RDATA,
    // control inputs and contacts
    input wire logic              STEP_TRIGGER_INPUT,
    input wire logic              HOLD_INPUT,
    input wire logic              RESUME_INPUT,
    input wire logic              ABORT_INPUT,
    input wire logic [PAT_W-1:0]  CONTACT_OUTPUTS
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SRST);
    // write then read of one offset
    sequence s_wr_rd(logic [ADDR_W-1:0] ofs);
        REG_WR && REG_ADDR == ofs ##1 REG_RD && REG_ADDR == ofs;
    endsequence
    property p_rd_idle;
        !$past(REG_RD) |-> REG_RDATA == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
    property p_rst_out;
        disable iff (1'b0) SRST [*2] |-> CONTACT_OUTPUTS == IDLE_PAT && REG_RDATA == '0;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("contacts not open in reset");
    property p_unmapped;
        REG_RD && REG_ADDR == 8'hFC |=> REG_RDATA == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_abort;
        $rose(ABORT_INPUT) |-> ##3 CONTACT_OUTPUTS == IDLE_PAT;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not open contacts");
    property p_ctrl_rb;
        s_wr_rd(CTRL_OFS) |=> REG_RDATA == DATA_W'($past(REG_WDATA[CTRL_W-1:0], 2));
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
    property p_pat_rb;
        s_wr_rd(8'h44) |=> REG_RDATA == DATA_W'($past(REG_WDATA[PAT_W-1:0], 2));
    endproperty
    a_pat_rb: assert property (p_pat_rb) else $error("pattern readback wrong");
    property p_pat0;
        s_wr_rd(PAT_BASE_OFS) |=> REG_RDATA == '0;
    endproperty
    a_pat0: assert property (p_pat0) else $error("idle pattern was altered");
    property p_intv_rb;
        s_wr_rd(8'h84) |=> REG_RDATA == DATA_W'($past(REG_WDATA[INTV_W-1:0], 2));
    endproperty
    a_intv_rb: assert property (p_intv_rb) else $error("interval readback wrong");
    // main scenarios reached
    c_abort: cover property ($rose(ABORT_INPUT));
    c_hold: cover property ($rose(HOLD_INPUT));
    c_step: cover property ($changed(CONTACT_OUTPUTS) && CONTACT_OUTPUTS != IDLE_PAT);
endmodule : fcs_seq_chk

bind fcs_sequencer fcs_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) fcs_seq_chk_i (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .STEP_TRIGGER_INPUT(STEP_TRIGGER_INPUT), .HOLD_INPUT(HOLD_INPUT),
    .RESUME_INPUT(RESUME_INPUT), .ABORT_INPUT(ABORT_INPUT),
    .CONTACT_OUTPUTS(CONTACT_OUTPUTS)
);

// *** test/fcs_ctl_src.sv ***
`timescale 1ns/1ps
module fcs_ctl_src
    import fcs_pkg::*;
(
    // clock
    input  wire logic            clk,
    // control levels toward the sequencer
    output logic      [IN_W-1:0] lvl
);
    initial lvl = '0;
    // one pulse of len cycles, then a low gap so edges stay apart
    task automatic pulse(input int lane, input int len);
        lvl[lane] <= 1'b1;
        repeat (len) @(posedge clk);
        lvl[lane] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse
endmodule : fcs_ctl_src

// *** test/fcs_sequencer_tb_top.sv ***
`timescale 1ns/1ps
module fcs_sequencer_tb_top;
    import fcs_pkg::*;
    localparam int unsigned TICK = 10;
    logic              SYS_CLK   = 1'b0;
    logic              SRST      = 1'b1;
    logic [ADDR_W-1:0] REG_ADDR  = '0;
    logic [DATA_W-1:0] REG_WDATA = '0;
    logic              REG_WR    = 1'b0;
    logic              REG_RD    = 1'b0;
    logic [DATA_W-1:0] REG_RDATA;
    logic [IN_W-1:0]   lvl;
    logic [PAT_W-1:0]  CONTACT_OUTPUTS;
    logic [PAT_W-1:0]  seq_exp [6] = '{4'hA, 4'hF, 4'h5, 4'hA, 4'hF, 4'h0};
    int                error_cnt  = 0;
    int                num_checks = 0;
    int                n;
    // system clock
    always #25 SYS_CLK = ~SYS_CLK;
    fcs_ctl_src fcs_ctl_src_i (.clk(SYS_CLK), .lvl(lvl));
    fcs_sequencer #(.TICK_CYCLES(TICK)) fcs_sequencer_i (
        .SYS_CLK(SYS_CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .STEP_TRIGGER_INPUT(lvl[IN_START]), .HOLD_INPUT(lvl[IN_HOLD]),
        .RESUME_INPUT(lvl[IN_RESUME]), .ABORT_INPUT(lvl[IN_ABORT]),
        .CONTACT_OUTPUTS(CONTACT_OUTPUTS)
    );
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            error_cnt++;
        end
    endtask : chk
    task automatic end_sim;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim
    // register access, entered right after an edge
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        #1 chk(REG_RDATA, exp);
        @(posedge SYS_CLK);
    endtask : rd_chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask : wr
    task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, exp);
        wr(a, d);
        rd_chk(a, exp);
    endtask : wr_rd
    // contact checks and bounded waits
    task automatic out_is(input logic [31:0] exp);
        #1 chk(32'(CONTACT_OUTPUTS), exp);
        @(posedge SYS_CLK);
    endtask : out_is
    task automatic wait_out(input logic [PAT_W-1:0] exp, input int max);
        n = 0;
        #1;
        while (CONTACT_OUTPUTS !== exp) begin
            if (n == max) begin
                error_cnt++;
                end_sim();
            end
            @(posedge SYS_CLK);
            #1 n++;
        end
        @(posedge SYS_CLK);
    endtask : wait_out
    task automatic rng(input int lo, input int hi);
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask : rng
    task automatic pls(input int lane, input int len);
        fcs_ctl_src_i.pulse(lane, len);
    endtask : pls
    // reset values, unmapped place, fixed idle step
    task automatic t_reset;
        rd_chk(CTRL_OFS, 32'h0);
        rd_chk(NSTEPS_OFS, 32'h1);
        rd_chk(REPEAT_OFS, 32'h1);
        rd_chk(8'hFC, 32'h0);
        out_is(32'h0);
        wr_rd(PAT_BASE_OFS, 32'hF, 32'h0);
    endtask : t_reset
    // pulse mode stepping, long pulse is one action
    task automatic t_pulse;
        wr_rd(NSTEPS_OFS, 32'h3, 32'h3);
        wr_rd(8'h44, 32'h5, 32'h5);
        wr_rd(8'h48, 32'hA, 32'hA);
        wr_rd(8'h4C, 32'hF, 32'hF);
        wr_rd(8'h84, 32'h2, 32'h2);
        wr_rd(8'h88, 32'h1, 32'h1);
        wr_rd(8'h8C, 32'h3, 32'h3);
        pls(IN_START, 1);
        out_is(32'h5);
        pls(IN_START, 6);
        out_is(32'hA);
        pls(IN_START, 1);
        out_is(32'hF);
        pls(IN_START, 1);
        out_is(32'h0);
    endtask : t_pulse
    // pause, resume and abort in pulse mode
    task automatic t_hold;
        pls(IN_START, 1);
        out_is(32'h5);
        pls(IN_HOLD, 1);
        pls(IN_START, 1);
        out_is(32'h5);
        rd_chk(STATUS_OFS, 32'h531);
        pls(IN_RESUME, 1);
        pls(IN_START, 1);
        out_is(32'hA);
        pls(IN_ABORT, 1);
        out_is(32'h0);
    endtask : t_hold
    // autostart, wrap to step 1, repetitions run out
    task automatic t_auto;
        wr(REPEAT_OFS, 32'h2);
        @(posedge SYS_CLK);
        wr_rd(CTRL_OFS, 32'h2, 32'h2);
        wait_out(4'h5, 10);
        out_is(32'h5);
        for (int i = 0; i < 6; i++) begin
            pls(IN_START, 1);
            out_is(32'(seq_exp[i]));
        end
        pls(IN_ABORT, 1);
        wait_out(4'h5, 10);
        out_is(32'h5);
        wr(CTRL_OFS, 32'h0);
        pls(IN_ABORT, 1);
        out_is(32'h0);
    endtask : t_auto
    // loop forever outlives a repeat count of one
    task automatic t_loop;
        wr(REPEAT_OFS, 32'h1);
        @(posedge SYS_CLK);
        wr(CTRL_OFS, 32'h6);
        wait_out(4'h5, 10);
        for (int i = 0; i < 3; i++) begin
            pls(IN_START, 1);
            out_is(32'(seq_exp[i]));
        end
        rd_chk(CYCLES_OFS, 32'h1);
        wr(REPEAT_OFS, 32'h2);
        @(posedge SYS_CLK);
        wr(CTRL_OFS, 32'h0);
        pls(IN_ABORT, 1);
        out_is(32'h0);
    endtask : t_loop
    // time mode schedule of 2, 1 and 3 ticks
    task automatic t_time;
        wr(CTRL_OFS, 32'h1);
        pls(IN_START, 1);
        out_is(32'h5);
        wait_out(4'hA, 60);
        rng(14, 22);
        wait_out(4'hF, 40);
        rng(6, 12);
        wait_out(4'h0, 60);
        rng(26, 32);
        repeat (40) @(posedge SYS_CLK);
        out_is(32'h0);
        rd_chk(CYCLES_OFS, 32'h1);
    endtask : t_time
    // time mode freeze, continue, abort, autostart
    task automatic t_time_hold;
        pls(IN_START, 1);
        out_is(32'h5);
        repeat (3) @(posedge SYS_CLK);
        pls(IN_HOLD, 1);
        repeat (40) @(posedge SYS_CLK);
        out_is(32'h5);
        rd_chk(REMAIN_OFS, 32'h2);
        pls(IN_RESUME, 1);
        wait_out(4'hA, 40);
        rng(5, 14);
        pls(IN_ABORT, 1);
        out_is(32'h0);
        wr(CTRL_OFS, 32'h3);
        wait_out(4'h5, 10);
        wait_out(4'hA, 40);
        rng(14, 22);
    endtask : t_time_hold
    // main sequence
    initial begin
        repeat (6) @(posedge SYS_CLK);
        SRST <= 1'b0;
        t_reset();
        t_pulse();
        t_hold();
        t_auto();
        t_loop();
        t_time();
        t_time_hold();
        end_sim();
    end
endmodule : fcs_sequencer_tb_top
